// file: src/eacs_pkg.sv
package eacs_pkg;

  localparam logic [6:0] EACS_INDEX = 7'h2A;
  localparam logic [15:0] EACS_NOMINAL_RESET = 16'h0400;
  localparam logic [15:0] EACS_RSVD_MASK = 16'h7BCA;
  localparam logic [15:0] EACS_LOCK_MASK = 16'hFFFE;
  localparam logic [15:0] EACS_RATE_48K = 16'hBB80;

  localparam int unsigned B_VFORCE = 15;
  localparam int unsigned B_CFG_OK = 10;
  localparam int unsigned B_SLOT_HI = 5;
  localparam int unsigned B_SLOT_LO = 4;
  localparam int unsigned B_SPDIF_EN = 2;
  localparam int unsigned B_VRA = 0;

  localparam int unsigned EACS_SAMPLE_W = 20;

  localparam logic [1:0] SEL_3_4 = 2'h0;
  localparam logic [1:0] SEL_7_8 = 2'h1;
  localparam logic [1:0] SEL_6_9 = 2'h2;
  localparam logic [1:0] SEL_10_11 = 2'h3;

  typedef enum logic [1:0] {
    PH_STRAP = 2'b01,
    PH_RUN = 2'b10
  } eacs_phase_t;

  typedef struct packed {
    logic vforce;
    logic [1:0] slot;
    logic spdif_en;
    logic variable_rate_enable;
  } eacs_ctrl_t;

  typedef struct packed {
    logic tick;
    logic sample_ok;
    logic tx_err;
    logic [EACS_SAMPLE_W-1:0] sample;
  } eacs_subframe_t;

  typedef struct packed {
    logic validity;
    logic [EACS_SAMPLE_W-1:0] sample;
  } eacs_sf_out_t;

  typedef struct packed {
    logic [3:0] left;
    logic [3:0] right;
  } eacs_slots_t;

  localparam eacs_slots_t SLOTS_3_4 = '{left: 4'h3, right: 4'h4};
  localparam eacs_slots_t SLOTS_7_8 = '{left: 4'h7, right: 4'h8};
  localparam eacs_slots_t SLOTS_6_9 = '{left: 4'h6, right: 4'h9};
  localparam eacs_slots_t SLOTS_10_11 = '{left: 4'hA, right: 4'hB};

  function automatic eacs_slots_t eacs_slot_map(input logic [1:0] sel);
    eacs_slots_t s;
    case (sel)
      SEL_3_4: s = SLOTS_3_4;
      SEL_7_8: s = SLOTS_7_8;
      SEL_6_9: s = SLOTS_6_9;
      default: s = SLOTS_10_11;
    endcase
    return s;
  endfunction

  function automatic logic [1:0] eacs_slot_reset(input logic [1:0] id);
    logic [1:0] s;
    case (id)
      2'h0: s = SEL_7_8;
      2'h3: s = SEL_10_11;
      default: s = SEL_6_9;
    endcase
    return s;
  endfunction

endpackage

// file: src/eacs_reg.sv
// Functional notes
// - register lives at index 2Ah, nominal reset 0400h, varies with identity straps.
// - disable strap high at power-up locks bits 15..1: writes ignored, reads zero.
// - validity-force bit 15 set drives sub-frame validity flag (bit 28) to zero.
// - validity-enable 1 and force 0: validity flag follows internal transmit error.
// - enable 0 and force 1: missing sample gives validity 0 and zero sample.
// - same mode, sample received and sent gives validity 0.
// - validity-enable and validity-force are zero after reset.
// - bit 10 reports configuration valid (1) or invalid (0), reset to 0.
// - unused bits 9..6 read as zero.
// - slot select resets by identity: 00->01, 01/10->10, 11->11.
// - slot select picks left/right link slots 3/4, 7/8, 6/9 or 10/11.
// - bit 2 enables output; when 0 pin floats and control writes allowed.
// - variable-rate bit 0 clear forces 48 kHz, rate registers loaded BB80h.
`timescale 1ns/1ps

module eacs_reg
  import eacs_pkg::*;
(
  input wire logic CORE_CLK,
  input wire logic RESET_N,
  input wire logic [1:0] CODEC_ID_STRAP,
  input wire logic SPDIF_OFF_STRAP,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [6:0] REG_INDEX,
  input wire logic [15:0] REG_WDATA,
  output logic [15:0] REG_RDATA,
  output logic REG_RVALID,
  input wire logic VALIDITY_EN,
  input wire logic CFG_OK_IN,
  input wire eacs_subframe_t SF_IN,
  output eacs_sf_out_t SF_OUT,
  output logic SF_OUT_VALID,
  output eacs_slots_t SPDIF_SLOTS,
  input wire logic SPDIF_SER_DATA,
  output logic SPDIF_OUT,
  output logic SPDIF_OUT_OE,
  output logic SPDIF_CTRL_WR_OK,
  output logic RATE_FORCE,
  output logic [15:0] RATE_FORCE_VALUE
);

  eacs_phase_t phase_q, phase_d;
  eacs_ctrl_t ctrl_q, ctrl_d;
  logic lock_q, lock_d;
  logic cfg_ok_q, cfg_ok_d;
  logic [15:0] rdata_q, rdata_d;
  logic rvalid_q, rvalid_d;
  eacs_sf_out_t sf_q, sf_d;
  logic sfv_q, sfv_d;
  eacs_slots_t slots_q, slots_d;
  logic spdif_out_q, spdif_out_d;
  logic rate_force_q, rate_force_d;
  logic [15:0] rate_val_q, rate_val_d;
  logic wr_hit;
  logic rd_hit;
  logic [15:0] reg_view;

  // only the one index answers; any other index reads as zero
  assign wr_hit = REG_WR && (REG_INDEX == EACS_INDEX);
  assign rd_hit = REG_RD && (REG_INDEX == EACS_INDEX);

  // control group: straps caught one edge after release, then writes
  always_comb
  begin
    phase_d = phase_q;
    ctrl_d = ctrl_q;
    lock_d = lock_q;
    case (phase_q)
      PH_STRAP:
      begin
        // straps are sampled by a clocked process, never by the reset itself
        lock_d = SPDIF_OFF_STRAP;
        ctrl_d.slot = eacs_slot_reset(CODEC_ID_STRAP);
        phase_d = PH_RUN;
      end
      PH_RUN:
      begin
        if (wr_hit)
        begin
          // bit 0 stays writable even when locked
          ctrl_d.variable_rate_enable = REG_WDATA[B_VRA];
          if (!lock_q)
          begin
            // status and reserved bits are not stored from writes
            ctrl_d.vforce = REG_WDATA[B_VFORCE];
            ctrl_d.slot = REG_WDATA[B_SLOT_HI:B_SLOT_LO];
            ctrl_d.spdif_en = REG_WDATA[B_SPDIF_EN];
          end
        end
      end
      default:
      begin
        phase_d = PH_STRAP;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      phase_q <= PH_STRAP;
      ctrl_q <= '0;
      lock_q <= 1'b0;
    end
    else
    begin
      phase_q <= phase_d;
      ctrl_q <= ctrl_d;
      lock_q <= lock_d;
    end
  end

  // register view and read port
  always_comb
  begin
    reg_view = '0;
    reg_view[B_VRA] = ctrl_q.variable_rate_enable;
    if (!lock_q)
    begin
      reg_view[B_VFORCE] = ctrl_q.vforce;
      reg_view[B_CFG_OK] = cfg_ok_q;
      reg_view[B_SLOT_HI:B_SLOT_LO] = ctrl_q.slot;
      reg_view[B_SPDIF_EN] = ctrl_q.spdif_en;
    end
    cfg_ok_d = CFG_OK_IN;
    rvalid_d = REG_RD;
    rdata_d = '0;
    if (rd_hit)
    begin
      rdata_d = reg_view;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      cfg_ok_q <= 1'b0;
      rdata_q <= '0;
      rvalid_q <= 1'b0;
    end
    else
    begin
      cfg_ok_q <= cfg_ok_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // sub-frame validity and sample padding
  always_comb
  begin
    sf_d = sf_q;
    sfv_d = 1'b0;
    if (SF_IN.tick)
    begin
      sfv_d = 1'b1;
      sf_d.sample = SF_IN.sample;
      sf_d.validity = 1'b0;
      if (ctrl_q.vforce)
      begin
        sf_d.validity = 1'b0;
        if (!VALIDITY_EN && !SF_IN.sample_ok)
        begin
          sf_d.sample = '0;
        end
      end
      else if (VALIDITY_EN)
      begin
        sf_d.validity = SF_IN.tx_err;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      sf_q <= '0;
      sfv_q <= 1'b0;
    end
    else
    begin
      sf_q <= sf_d;
      sfv_q <= sfv_d;
    end
  end

  // slot routing, output pin and rate override
  always_comb
  begin
    slots_d = eacs_slot_map(ctrl_q.slot);
    // serializer data is gated so a disabled pin holds its last serializer bit one cycle, then shows zero
    spdif_out_d = SPDIF_SER_DATA && ctrl_q.spdif_en;
    rate_force_d = !ctrl_q.variable_rate_enable;
    rate_val_d = EACS_RATE_48K;
  end

  always_ff @(posedge CORE_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      slots_q <= SLOTS_3_4;
      spdif_out_q <= 1'b0;
      rate_force_q <= 1'b1;
      rate_val_q <= EACS_RATE_48K;
    end
    else
    begin
      slots_q <= slots_d;
      spdif_out_q <= spdif_out_d;
      rate_force_q <= rate_force_d;
      rate_val_q <= rate_val_d;
    end
  end

  assign REG_RDATA = rdata_q;
  assign REG_RVALID = rvalid_q;
  assign SF_OUT = sf_q;
  assign SF_OUT_VALID = sfv_q;
  assign SPDIF_SLOTS = slots_q;
  assign SPDIF_OUT = spdif_out_q;
  // pin floats while the transmitter is off
  assign SPDIF_OUT_OE = ctrl_q.spdif_en;
  assign SPDIF_CTRL_WR_OK = !ctrl_q.spdif_en;
  assign RATE_FORCE = rate_force_q;
  assign RATE_FORCE_VALUE = rate_val_q;

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RESET_N);

  a_read_index: assert property (
    REG_RD && (REG_INDEX != EACS_INDEX) |=> REG_RVALID && (REG_RDATA == '0))
    else $error("foreign index did not read zero");

  a_lock_reads: assert property (
    rd_hit && lock_q |=> (REG_RDATA & EACS_LOCK_MASK) == '0)
    else $error("locked register showed upper bits");

  a_lock_write: assert property (
    wr_hit && lock_q |=> ctrl_q.spdif_en == $past(ctrl_q.spdif_en) && ctrl_q.vforce == $past(ctrl_q.vforce))
    else $error("locked register accepted a write");

  a_force_flag: assert property (
    SF_IN.tick && ctrl_q.vforce |=> SF_OUT_VALID && !SF_OUT.validity)
    else $error("forced validity flag not cleared");

  a_error_flag: assert property (
    SF_IN.tick && !ctrl_q.vforce && VALIDITY_EN |=> SF_OUT.validity == $past(SF_IN.tx_err))
    else $error("validity flag does not track transmit error");

  a_pad_zero: assert property (
    SF_IN.tick && ctrl_q.vforce && !VALIDITY_EN && !SF_IN.sample_ok |=> SF_OUT.sample == '0)
    else $error("missing sample not padded with zeros");

  a_good_sample: assert property (
    SF_IN.tick && ctrl_q.vforce && SF_IN.sample_ok |=> SF_OUT.sample == $past(SF_IN.sample) && !SF_OUT.validity)
    else $error("good sample altered or flagged");

  a_reset_clear: assert property (
    phase_q == PH_STRAP |-> !ctrl_q.vforce && !ctrl_q.spdif_en && !ctrl_q.variable_rate_enable)
    else $error("control bits not clear out of reset");

  a_cfg_report: assert property (
    rd_hit && !lock_q ##1 1'b1 |-> REG_RDATA[B_CFG_OK] == $past(cfg_ok_q))
    else $error("configuration flag misreported");

  a_rsvd_zero: assert property (
    REG_RVALID |-> (REG_RDATA & EACS_RSVD_MASK) == '0)
    else $error("reserved bits read nonzero");

  a_slot_reset: assert property (
    phase_q == PH_STRAP |=> ctrl_q.slot == eacs_slot_reset($past(CODEC_ID_STRAP)))
    else $error("slot select reset value wrong");

  a_slot_route: assert property (
    phase_q == PH_RUN ##1 1'b1 |-> SPDIF_SLOTS == eacs_slot_map($past(ctrl_q.slot)))
    else $error("slot routing mismatch");

  a_pin_float: assert property (
    $fell(ctrl_q.spdif_en) |-> !SPDIF_OUT_OE && SPDIF_CTRL_WR_OK ##1 !SPDIF_OUT)
    else $error("disabled output still driven");

  a_rate_force: assert property (
    !ctrl_q.variable_rate_enable |=> RATE_FORCE && RATE_FORCE_VALUE == EACS_RATE_48K)
    else $error("rate not forced to 48 kHz");

  // bit 10 must come from the configuration status input CFG_OK_IN two edges back, never from a write
  a_status_ro: assert property (
    rd_hit && !lock_q |=> REG_RDATA[B_CFG_OK] == $past(CFG_OK_IN, 2))
    else $error("status bit not taken from status input");

  a_enable_write: assert property (
    wr_hit && !lock_q |=> SPDIF_OUT_OE == $past(REG_WDATA[B_SPDIF_EN]) && SPDIF_CTRL_WR_OK == !SPDIF_OUT_OE)
    else $error("transmitter enable not taken from write");

  a_rate_write: assert property (
    wr_hit |=> ctrl_q.variable_rate_enable == $past(REG_WDATA[B_VRA]))
    else $error("variable rate bit not written");

endmodule // eacs_reg

// file: sim/eacs_link_ctrl.sv
`timescale 1ns/1ps

module eacs_link_ctrl
  import eacs_pkg::*;
(
  input wire logic clk,
  output logic wr,
  output logic rd,
  output logic [6:0] idx,
  output logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic rvalid
);
  initial
  begin
    wr = 1'b0;
    rd = 1'b0;
    idx = 7'h00;
    wdata = 16'h0000;
  end

  // one-cycle strobes launched off the falling edge, held over the taking edge
  task automatic reg_wr(input logic [6:0] i, input logic [15:0] d);
    @(negedge clk);
    wr = 1'b1;
    idx = i;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    // stale data must not look like a valid word
    wdata = ~d;
  endtask

  task automatic reg_rd(input logic [6:0] i, output logic [15:0] d, output logic v);
    @(negedge clk);
    rd = 1'b1;
    idx = i;
    @(negedge clk);
    rd = 1'b0;
    d = rdata;
    v = rvalid;
  endtask
endmodule // eacs_link_ctrl

// file: sim/eacs_bench.sv
`timescale 1ns/1ps

module ext_audio_ctrl_status_reg_bench
  import eacs_pkg::*;
;
  localparam logic [7:0] SLT [4] = '{8'h34, 8'h78, 8'h69, 8'hab};
  logic CORE_CLK;
  logic RESET_N;
  logic off;
  logic vld_en;
  logic cfg_ok;
  logic ser;
  logic [1:0] id;
  eacs_subframe_t sf_in;
  eacs_sf_out_t sf_out;
  eacs_slots_t slots;
  logic wr;
  logic rd;
  logic rvalid;
  logic sfv;
  logic sout;
  logic oe;
  logic wok;
  logic rf;
  logic [6:0] idx;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic [15:0] rfv;
  logic [15:0] r;
  logic [15:0] d;
  logic v;
  logic [31:0] seed;
  int n_fail;
  int n_checks;

  eacs_reg DUT (.CORE_CLK(CORE_CLK), .RESET_N(RESET_N), .CODEC_ID_STRAP(id), .SPDIF_OFF_STRAP(off),
    .REG_WR(wr), .REG_RD(rd), .REG_INDEX(idx), .REG_WDATA(wdata), .REG_RDATA(rdata), .REG_RVALID(rvalid),
    .VALIDITY_EN(vld_en), .CFG_OK_IN(cfg_ok), .SF_IN(sf_in), .SF_OUT(sf_out), .SF_OUT_VALID(sfv),
    .SPDIF_SLOTS(slots), .SPDIF_SER_DATA(ser), .SPDIF_OUT(sout), .SPDIF_OUT_OE(oe),
    .SPDIF_CTRL_WR_OK(wok), .RATE_FORCE(rf), .RATE_FORCE_VALUE(rfv));

  eacs_link_ctrl m (.clk(CORE_CLK), .wr(wr), .rd(rd), .idx(idx), .wdata(wdata), .rdata(rdata),
    .rvalid(rvalid));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [1:0] slot_rst(input logic [1:0] i);
    return (i == 2'h0) ? 2'h1 : (i == 2'h3) ? 2'h3 : 2'h2;
  endfunction

  function automatic logic [20:0] exp_sf(input logic vf, input logic vb, input logic ok,
    input logic err, input logic [19:0] s);
    if (vf)
      return {1'b0, (!vb && !ok) ? 20'h0_0000 : s};
    return {vb & err, s};
  endfunction

  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // straps stay put after release: they are sampled on the first edge
  task automatic do_reset(input logic [1:0] i, input logic o);
    @(negedge CORE_CLK);
    RESET_N = 1'b0;
    id = i;
    off = o;
    repeat (12) @(negedge CORE_CLK);
    RESET_N = 1'b1;
    repeat (2) @(negedge CORE_CLK);
  endtask

  initial
  begin
    CORE_CLK = 1'b0;
    forever #10 CORE_CLK = ~CORE_CLK;
  end

  initial
  begin
    repeat (5000) @(posedge CORE_CLK);
    n_fail++;
    tally_and_finish();
  end

  initial
  begin
    RESET_N = 1'b0;
    id = 2'h0;
    off = 1'b0;
    vld_en = 1'b0;
    cfg_ok = 1'b0;
    ser = 1'b0;
    sf_in = '0;
    n_fail = 0;
    n_checks = 0;
    seed = 32'h0000_2cf0;
    for (int i = 0; i < 4; i++)
    begin
      do_reset(i[1:0], 1'b0);
      m.reg_rd(7'h2a, r, v);
      chk({v, r}, {1'b1, 10'h000, slot_rst(i[1:0]), 4'h0});
      chk(slots, SLT[slot_rst(i[1:0])]);
      m.reg_rd(7'h2b, r, v);
      chk({v, r}, 17'h1_0000);
    end
    for (int k = 0; k < 40; k++)
    begin
      seed = lfsr(seed);
      d = seed[15:0];
      cfg_ok = seed[16];
      vld_en = seed[17];
      ser = seed[20];
      m.reg_wr(7'h2a, d);
      m.reg_wr(7'h28, ~d);
      m.reg_rd(7'h2a, r, v);
      chk(r, (d & 16'h8035) | {5'h00, cfg_ok, 10'h000});
      chk({slots, oe, wok, rf, sout, rfv}, {SLT[d[5:4]], d[2], ~d[2], ~d[0], ser & d[2], 16'hbb80});
      sf_in = {1'b1, seed[18], seed[19], seed[31:12]};
      @(negedge CORE_CLK);
      chk({sfv, sf_out}, {1'b1, exp_sf(d[15], vld_en, seed[18], seed[19], seed[31:12])});
      sf_in.tick = 1'b0;
    end
    // every force/enable/sample-ok combination once, with a transmit error present
    for (int c = 0; c < 8; c++)
    begin
      vld_en = c[1];
      m.reg_wr(7'h2a, {c[2], 15'h0000});
      sf_in = {1'b1, c[0], 1'b1, 20'ha_5a5a};
      @(negedge CORE_CLK);
      chk({sfv, sf_out}, {1'b1, exp_sf(c[2], c[1], c[0], 1'b1, 20'ha_5a5a)});
      sf_in.tick = 1'b0;
    end
    do_reset(2'h3, 1'b1);
    cfg_ok = 1'b1;
    m.reg_wr(7'h2a, 16'hffff);
    m.reg_rd(7'h2a, r, v);
    chk({r, oe, rf}, {16'h0001, 1'b0, 1'b0});
    tally_and_finish();
  end
endmodule // ext_audio_ctrl_status_reg_bench
